// File: verilog/rcr_reset_cause_recorder.sv
`timescale 1ns/100ps
// Behaviour
// - a reset arriving during a RAM access is held back until the access ends.
// - pins stay high impedance through reset until software configures them.
// - the three upper cause bits read zero and ignore writes.
// - the external flag is set by an external reset and kept by other resets.
// - the watchdog flag is set by a watchdog reset and kept by other resets.
// - the power-on flag is set by power-on or low-voltage reset and kept by others.
// - the hardware flag is set by any non-software reset and kept by a software reset.
// - the software flag is set by a software reset and kept by external and watchdog resets.
// - a power-on reset clears the software flag and sets power-on and hardware flags.
// - any read or any write of the cause register clears all five flags.
// - software must save the cause register before use since reading erases it.
// - the oscillation wait setting is reinitialised only by a power-on or low-voltage reset.
// - a started watchdog that is not cleared within its period raises a reset.
module rcr_reset_cause_recorder #(
	parameter int WDOG_PERIOD = rcr_pkg::WDOG_PERIOD_CYCLES
) (
	input  wire logic        mclk_i,
	input  wire logic        reset_i,
	input  wire logic        ext_reset_n_i,
	input  wire logic        low_volt_i,
	input  wire logic        ram_busy_i,
	output logic             int_reset_o,
	output logic [7:0]       pin_out_o,
	output logic [7:0]       pin_oe_o,
	output logic [7:0]       osc_wait_setting_o,
	output logic             irq_o,
	input  wire logic [7:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic [31:0]      avs_readdata_o,
	output logic             avs_waitrequest_o
);

	// ==========================================================
	// flag update for one recorded reset
	function automatic logic [7:0] apply_cause(input logic [7:0] cur, input rcr_pkg::rcr_src_t src);
		logic [7:0] f;
		f = cur;
		case (src)
			rcr_pkg::SRC_POR:
			begin
				f[rcr_pkg::CAUSE_PON] = 1'b1;
				f[rcr_pkg::CAUSE_HW]  = 1'b1;
				f[rcr_pkg::CAUSE_SW]  = 1'b0;
			end
			rcr_pkg::SRC_EXT:
			begin
				f[rcr_pkg::CAUSE_EXT] = 1'b1;
				f[rcr_pkg::CAUSE_HW]  = 1'b1;
			end
			rcr_pkg::SRC_WDOG:
			begin
				f[rcr_pkg::CAUSE_WDOG] = 1'b1;
				f[rcr_pkg::CAUSE_HW]   = 1'b1;
			end
			rcr_pkg::SRC_SW:
				f[rcr_pkg::CAUSE_SW] = 1'b1;
			default:
				f = cur;
		endcase
		return f & rcr_pkg::CAUSE_MASK;
	endfunction

	// ==========================================================
	// pin synchronisers: reset pin and low-voltage detector
	logic [1:0] sync1_reg;
	logic [1:0] sync2_reg;

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			sync1_reg <= 2'h1;
			sync2_reg <= 2'h1;
		end
		else
		begin
			sync1_reg <= {low_volt_i, ext_reset_n_i};
			sync2_reg <= sync1_reg;
		end
	end

	wire ext_low = ~sync2_reg[0];
	wire lvd_hit = sync2_reg[1];

	// ==========================================================
	// bus decode
	logic ack_reg;
	wire  req       = avs_read_i | avs_write_i;
	wire  accept    = req & ack_reg;
	wire  wr_acc    = accept & avs_write_i & avs_byteenable_i[0];
	wire  sel_cause = avs_address_i == rcr_pkg::ADDR_CAUSE;
	wire  sel_ctrl  = avs_address_i == rcr_pkg::ADDR_CTRL;
	wire  sel_oscw  = avs_address_i == rcr_pkg::ADDR_OSC_WAIT;
	wire  sel_pcfg  = avs_address_i == rcr_pkg::ADDR_PIN_CFG;
	wire  sel_pout  = avs_address_i == rcr_pkg::ADDR_PIN_OUT;
	wire  sel_istat = avs_address_i == rcr_pkg::ADDR_IRQ_STAT;
	wire  sel_imask = avs_address_i == rcr_pkg::ADDR_IRQ_MASK;
	wire [7:0] wbyte = avs_writedata_i[7:0];

	// every access, read or write, whatever the data, is accepted on the second edge
	assign avs_waitrequest_o = req & ~ack_reg;

	// any access to the cause register clears the cause flags; the data was latched one edge earlier
	wire cause_clear = accept & sel_cause;

	wire sw_req   = wr_acc & sel_ctrl & wbyte[rcr_pkg::CTRL_SW_RESET];
	wire wd_start = wr_acc & sel_ctrl & wbyte[rcr_pkg::CTRL_WD_START];
	wire wd_clear = wr_acc & sel_ctrl & wbyte[rcr_pkg::CTRL_WD_CLEAR];

	// ==========================================================
	// watchdog
	logic        wd_run_reg;
	logic [31:0] wd_cnt_reg;
	wire wd_expire = wd_run_reg & (wd_cnt_reg == 32'(WDOG_PERIOD - 1));

	// ==========================================================
	// reset sequencer
	rcr_pkg::rcr_state_t state_reg;
	rcr_pkg::rcr_state_t state_next;
	rcr_pkg::rcr_src_t   src_reg;
	rcr_pkg::rcr_src_t   src_next;
	logic [1:0]          hold_reg;
	logic [1:0]          hold_next;

	// power-on outranks external, watchdog and software requests
	wire rcr_pkg::rcr_src_t src_new =
		lvd_hit   ? rcr_pkg::SRC_POR  :
		ext_low   ? rcr_pkg::SRC_EXT  :
		wd_expire ? rcr_pkg::SRC_WDOG :
		sw_req    ? rcr_pkg::SRC_SW   : rcr_pkg::SRC_NONE;
	wire src_any = src_new != rcr_pkg::SRC_NONE;

	// the flags are recorded on the edge the internal reset begins
	wire enter_hold = (state_reg == rcr_pkg::ST_RUN & src_any & ~ram_busy_i)
		| (state_reg == rcr_pkg::ST_DEFER & ~ram_busy_i);
	wire rcr_pkg::rcr_src_t src_rec = (state_reg == rcr_pkg::ST_DEFER) ? src_reg : src_new;
	wire defer_start = state_reg == rcr_pkg::ST_RUN & src_any & ram_busy_i;
	wire hold_done   = state_reg == rcr_pkg::ST_HOLD & hold_reg == 2'h0
		& ~(src_reg == rcr_pkg::SRC_EXT & ext_low);

	always_comb
	begin
		state_next = state_reg;
		src_next   = src_reg;
		hold_next  = hold_reg;
		case (state_reg)
			rcr_pkg::ST_RUN:
			begin
				if (src_any)
				begin
					src_next = src_new;
					if (ram_busy_i)
						state_next = rcr_pkg::ST_DEFER;
					else
					begin
						state_next = rcr_pkg::ST_HOLD;
						hold_next  = rcr_pkg::RESET_HOLD_CYCLES - 2'h1;
					end
				end
			end
			rcr_pkg::ST_DEFER:
			begin
				// the word write finishes before the internal reset strikes
				if (~ram_busy_i)
				begin
					state_next = rcr_pkg::ST_HOLD;
					hold_next  = rcr_pkg::RESET_HOLD_CYCLES - 2'h1;
				end
			end
			rcr_pkg::ST_HOLD:
			begin
				if (hold_reg != 2'h0)
					hold_next = hold_reg - 2'h1;
				else if (hold_done)
				begin
					state_next = rcr_pkg::ST_RUN;
					src_next   = rcr_pkg::SRC_NONE;
				end
			end
			default:
				state_next = rcr_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			state_reg <= rcr_pkg::ST_HOLD;
			src_reg   <= rcr_pkg::SRC_POR;
			hold_reg  <= rcr_pkg::RESET_HOLD_CYCLES - 2'h1;
		end
		else
		begin
			state_reg <= state_next;
			src_reg   <= src_next;
			hold_reg  <= hold_next;
		end
	end

	assign int_reset_o = state_reg == rcr_pkg::ST_HOLD;

	// ==========================================================
	// cause register: a recorded reset wins over an access clear
	logic [7:0] cause_reg;
	wire  [7:0] cause_base = cause_clear ? 8'h00 : cause_reg;
	wire  [7:0] cause_next = enter_hold ? apply_cause(cause_base, src_rec) : cause_base;

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
			cause_reg <= rcr_pkg::CAUSE_RESET;
		else
			cause_reg <= cause_next;
	end

	// ==========================================================
	// pin configuration held in reset while any internal reset is active; oscillation wait only during a power-on one
	wire por_hold = int_reset_o & src_reg == rcr_pkg::SRC_POR;
	logic [7:0] osc_wait_reg;
	logic [7:0] pin_cfg_reg;
	logic [7:0] pin_out_reg;

	always_ff @(posedge mclk_i)
	begin
		if (reset_i | por_hold)
			osc_wait_reg <= rcr_pkg::OSC_WAIT_RESET;
		else if (wr_acc & sel_oscw)
			osc_wait_reg <= wbyte;
	end

	always_ff @(posedge mclk_i)
	begin
		if (reset_i | int_reset_o)
		begin
			pin_cfg_reg <= rcr_pkg::PIN_CFG_RESET;
			pin_out_reg <= rcr_pkg::PIN_OUT_RESET;
		end
		else
		begin
			if (wr_acc & sel_pcfg)
				pin_cfg_reg <= wbyte;
			if (wr_acc & sel_pout)
				pin_out_reg <= wbyte;
		end
	end

	// a pin drives only once software has enabled it and never during reset
	assign pin_oe_o           = int_reset_o ? 8'h00 : pin_cfg_reg;
	assign pin_out_o          = pin_out_reg;
	assign osc_wait_setting_o = osc_wait_reg;

	// ==========================================================
	// watchdog counter, stopped by any reset
	always_ff @(posedge mclk_i)
	begin
		if (reset_i | int_reset_o)
		begin
			wd_run_reg <= 1'b0;
			wd_cnt_reg <= 32'h0;
		end
		else
		begin
			if (wd_start)
				wd_run_reg <= 1'b1;
			if (wd_clear | wd_expire | ~wd_run_reg)
				wd_cnt_reg <= 32'h0;
			else
				wd_cnt_reg <= wd_cnt_reg + 32'h1;
		end
	end

	// ==========================================================
	// interrupts: sticky events, write one to clear, set wins
	localparam int IRQ_W = rcr_pkg::IRQ_BITS;
	logic [IRQ_W-1:0] irq_stat_reg;
	logic [IRQ_W-1:0] irq_mask_reg;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;

	assign irq_set[rcr_pkg::IRQ_RESET_DONE] = hold_done;
	assign irq_set[rcr_pkg::IRQ_RAM_DEFER]  = defer_start;
	assign irq_clr = (wr_acc & sel_istat) ? wbyte[IRQ_W-1:0] : '0;

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			irq_stat_reg <= '0;
			irq_mask_reg <= '0;
		end
		else
		begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
			if (wr_acc & sel_imask)
				irq_mask_reg <= wbyte[IRQ_W-1:0];
		end
	end

	assign irq_o = |(irq_stat_reg & irq_mask_reg);

	// ==========================================================
	// read data: latched on the first edge, before the clear
	logic [31:0] rdata_reg;
	logic [7:0]  rmux;

	always_comb
	begin
		rmux = 8'h00;
		if (sel_cause)
			rmux = cause_reg & rcr_pkg::CAUSE_MASK;
		else if (sel_ctrl)
			rmux = {7'h00, wd_run_reg} << rcr_pkg::CTRL_WD_START;
		else if (sel_oscw)
			rmux = osc_wait_reg;
		else if (sel_pcfg)
			rmux = pin_cfg_reg;
		else if (sel_pout)
			rmux = pin_out_reg;
		else if (sel_istat)
			rmux = {{(8 - IRQ_W){1'b0}}, irq_stat_reg};
		else if (sel_imask)
			rmux = {{(8 - IRQ_W){1'b0}}, irq_mask_reg};
	end

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h0;
		end
		else
		begin
			ack_reg <= req & ~ack_reg;
			if (avs_read_i & ~ack_reg)
				rdata_reg <= {24'h0, rmux};
		end
	end

	assign avs_readdata_o = rdata_reg;

endmodule

// File: verilog/rcr_pkg.sv
package rcr_pkg;

	// ==========================================================
	// register map (byte addresses, one word each)
	localparam logic [7:0] ADDR_CAUSE    = 8'h00;
	localparam logic [7:0] ADDR_CTRL     = 8'h04;
	localparam logic [7:0] ADDR_OSC_WAIT = 8'h08;
	localparam logic [7:0] ADDR_PIN_CFG  = 8'h0C;
	localparam logic [7:0] ADDR_PIN_OUT  = 8'h10;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

	// ==========================================================
	// reset cause field positions
	localparam int CAUSE_SW   = 0;
	localparam int CAUSE_HW   = 1;
	localparam int CAUSE_PON  = 2;
	localparam int CAUSE_WDOG = 3;
	localparam int CAUSE_EXT  = 4;
	localparam logic [7:0] CAUSE_MASK = 8'h1F;

	// control register bit positions (write-one actions)
	localparam int CTRL_SW_RESET = 0;
	localparam int CTRL_WD_START = 1;
	localparam int CTRL_WD_CLEAR = 2;

	// interrupt status bit positions
	localparam int IRQ_RESET_DONE = 0;
	localparam int IRQ_RAM_DEFER  = 1;
	localparam int IRQ_BITS       = 2;

	// ==========================================================
	// reset values
	localparam logic [7:0] CAUSE_RESET    = 8'h06;
	localparam logic [7:0] OSC_WAIT_RESET = 8'hFF;
	localparam logic [7:0] PIN_CFG_RESET  = 8'h00;
	localparam logic [7:0] PIN_OUT_RESET  = 8'h00;

	// ==========================================================
	// timing: internal reset lasts at least this many machine cycles, longer while the reset pin stays low after an external reset
	localparam logic [1:0] RESET_HOLD_CYCLES = 2'h3;
	localparam int WDOG_PERIOD_CYCLES = 65536;

	// ==========================================================
	// types
	typedef enum logic [2:0] {SRC_NONE, SRC_POR, SRC_EXT, SRC_WDOG, SRC_SW} rcr_src_t;
	typedef enum logic [1:0] {ST_RUN, ST_DEFER, ST_HOLD} rcr_state_t;

endpackage

// File: testbench/rcr_cpu_model.sv
`timescale 1ns/100ps
// ==========================================================
// bus master standing in for the cpu core
module rcr_cpu_model (
	input  wire logic        mclk_i,
	input  wire logic        waitrequest_i,
	input  wire logic [31:0] readdata_i,
	output logic [7:0]       address_o,
	output logic             read_o,
	output logic             write_o,
	output logic [31:0]      writedata_o,
	output logic [3:0]       byteenable_o
);
	initial
	begin
		address_o = 8'h00;
		read_o = 1'b0;
		write_o = 1'b0;
		writedata_o = 32'h00000000;
		byteenable_o = 4'hF;
	end

	// request held until waitrequest is seen low at a rising edge
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge mclk_i);
		address_o <= a;
		writedata_o <= {24'h000000, d};
		read_o <= !wr;
		write_o <= wr;
		// no cycle count is assumed; only the bench watchdog ends a hung wait
		do
			@(posedge mclk_i);
		while (waitrequest_i !== 1'b0);
		q = readdata_i;
		read_o <= 1'b0;
		write_o <= 1'b0;
	endtask
endmodule

// File: testbench/rcr_reset_cause_recorder_assertions.sv
`timescale 1ns/100ps
// ==========================================================
// port-level checks
module rcr_reset_cause_recorder_checker (
	input wire logic        mclk_i,
	input wire logic        reset_i,
	input wire logic        ext_reset_n_i,
	input wire logic        ram_busy_i,
	input wire logic        int_reset_o,
	input wire logic [7:0]  pin_oe_o,
	input wire logic [7:0]  osc_wait_setting_o,
	input wire logic [7:0]  avs_address_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);

	sequence read_done_s;
		avs_read_i && !avs_waitrequest_o;
	endsequence
	sequence ext_held_s;
		(!ext_reset_n_i && !ram_busy_i) [*8];
	endsequence

	pins_hiz_a: assert property (int_reset_o |-> pin_oe_o == 8'h00)
		else $error("pins driven during reset");
	pins_release_a: assert property ($fell(int_reset_o) |-> pin_oe_o == 8'h00)
		else $error("pins driven at reset release");
	upper_zero_a: assert property (read_done_s |-> avs_readdata_o[31:5] == 27'h0)
		else $error("upper read bits not zero");
	ram_defer_a: assert property (ram_busy_i && !int_reset_o |=> !int_reset_o)
		else $error("reset entered during ram access");
	hold_three_a: assert property ($rose(int_reset_o) |-> int_reset_o [*3])
		else $error("internal reset shorter than three cycles");
	ext_reset_a: assert property (ext_held_s |-> int_reset_o)
		else $error("external reset not applied");
	osc_keep_a: assert property ($changed(osc_wait_setting_o) &&
		osc_wait_setting_o != 8'hFF
		|-> $past(avs_write_i) && $past(avs_address_i) == rcr_pkg::ADDR_OSC_WAIT)
		else $error("osc wait setting changed without a write");
	read_stand_a: assert property (read_done_s |=> $stable(avs_readdata_o))
		else $error("read data disturbed by clear");
	access_ack_a: assert property (avs_read_i || avs_write_i |-> ##[0:1] !avs_waitrequest_o)
		else $error("access not accepted in time");
endmodule

bind rcr_reset_cause_recorder rcr_reset_cause_recorder_checker u_rcr_reset_cause_recorder_checker (.*);

// File: testbench/reset_cause_recorder_test.sv
`timescale 1ns/100ps
module reset_cause_recorder_test;
	logic        mclk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        ext_reset_n_i = 1'b1;
	logic        low_volt_i = 1'b0;
	logic        ram_busy_i = 1'b0;
	logic        int_reset_o;
	logic        irq_o;
	logic [7:0]  pin_oe_o;
	logic [7:0]  pin_out_o;
	logic [7:0]  osc_wait_setting_o;
	logic [7:0]  address;
	logic        rd;
	logic        wr;
	logic [31:0] wdata;
	logic [3:0]  be;
	logic [31:0] rdata;
	logic        waitreq;
	logic [31:0] q;
	int          fail_count = 0;
	int          n_tests = 0;

	always #2.5 mclk_i = !mclk_i;

	rcr_reset_cause_recorder #(.WDOG_PERIOD(16)) u_rcr_reset_cause_recorder (
		.mclk_i(mclk_i), .reset_i(reset_i), .ext_reset_n_i(ext_reset_n_i),
		.low_volt_i(low_volt_i), .ram_busy_i(ram_busy_i), .int_reset_o(int_reset_o),
		.pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .osc_wait_setting_o(osc_wait_setting_o),
		.irq_o(irq_o), .avs_address_i(address), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata),
		.avs_waitrequest_o(waitreq));

	rcr_cpu_model u_rcr_cpu_model (
		.mclk_i(mclk_i), .waitrequest_i(waitreq), .readdata_i(rdata), .address_o(address),
		.read_o(rd), .write_o(wr), .writedata_o(wdata), .byteenable_o(be));

	// ==========================================================
	// helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		u_rcr_cpu_model.access(1'b0, a, 8'h00, q);
		check(q, {24'h000000, exp});
	endtask

	task automatic wrc(input logic [7:0] a, input logic [7:0] d);
		u_rcr_cpu_model.access(1'b1, a, d, q);
		// let the write settle before any output is compared
		@(negedge mclk_i);
	endtask

	// waits for one whole internal reset, bounded
	task automatic wait_rst();
		int n;
		@(negedge mclk_i);
		for (n = 0; n < 60 && int_reset_o !== 1'b1; n++) @(negedge mclk_i);
		check({31'h0, int_reset_o}, 32'h1);
		for (n = 0; n < 60 && int_reset_o !== 1'b0; n++) @(negedge mclk_i);
		check({31'h0, int_reset_o}, 32'h0);
	endtask

	task automatic pulse_pin(input int which);
		@(posedge mclk_i);
		if (which == 0) ext_reset_n_i <= 1'b0;
		else low_volt_i <= 1'b1;
		repeat (10) @(posedge mclk_i);
		ext_reset_n_i <= 1'b1;
		low_volt_i <= 1'b0;
		wait_rst();
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ==========================================================
	// scenarios
	task automatic t_por();
		rdc(rcr_pkg::ADDR_CAUSE, 8'h06);
		rdc(rcr_pkg::ADDR_CAUSE, 8'h00);
		check(pin_oe_o, 8'h00);
	endtask

	task automatic t_sw();
		wrc(rcr_pkg::ADDR_OSC_WAIT, 8'h55);
		wrc(rcr_pkg::ADDR_PIN_CFG, 8'hFF);
		check(pin_oe_o, 8'hFF);
		wrc(rcr_pkg::ADDR_PIN_OUT, 8'hA5);
		check(pin_out_o, 8'hA5);
		wrc(rcr_pkg::ADDR_CTRL, 8'h01);
		wait_rst();
		check(pin_oe_o, 8'h00);
		check(pin_out_o, 8'h00);
		check(osc_wait_setting_o, 8'h55);
		rdc(rcr_pkg::ADDR_CAUSE, 8'h01);
	endtask

	// flags from different resets pile up until read, except that power-on clears the software flag
	task automatic t_mix();
		pulse_pin(0);
		wrc(rcr_pkg::ADDR_CTRL, 8'h01);
		wait_rst();
		rdc(rcr_pkg::ADDR_CAUSE, 8'h13);
		wrc(rcr_pkg::ADDR_CTRL, 8'h02);
		wait_rst();
		wrc(rcr_pkg::ADDR_CTRL, 8'h01);
		wait_rst();
		pulse_pin(1);
		rdc(rcr_pkg::ADDR_CAUSE, 8'h0E);
		check(osc_wait_setting_o, 8'hFF);
	endtask

	task automatic t_ram();
		ram_busy_i <= 1'b1;
		wrc(rcr_pkg::ADDR_CTRL, 8'h01);
		repeat (5)
		begin
			@(negedge mclk_i);
			check({31'h0, int_reset_o}, 32'h0);
		end
		@(posedge mclk_i);
		ram_busy_i <= 1'b0;
		wait_rst();
		wrc(rcr_pkg::ADDR_CAUSE, 8'hFF);
		rdc(rcr_pkg::ADDR_CAUSE, 8'h00);
	endtask

	// a cleared watchdog restarts its period; left alone it resets the block
	task automatic t_wdog();
		wrc(rcr_pkg::ADDR_CTRL, 8'h02);
		rdc(rcr_pkg::ADDR_CTRL, 8'h02);
		repeat (4) @(posedge mclk_i);
		wrc(rcr_pkg::ADDR_CTRL, 8'h04);
		repeat (12)
		begin
			@(negedge mclk_i);
			check({31'h0, int_reset_o}, 32'h0);
		end
		wait_rst();
		rdc(rcr_pkg::ADDR_CAUSE, 8'h0A);
	endtask

	task automatic t_irq();
		rdc(rcr_pkg::ADDR_IRQ_STAT, 8'h03);
		wrc(rcr_pkg::ADDR_IRQ_MASK, 8'h01);
		check({31'h0, irq_o}, 32'h1);
		wrc(rcr_pkg::ADDR_IRQ_MASK, 8'h00);
		check({31'h0, irq_o}, 32'h0);
		wrc(rcr_pkg::ADDR_IRQ_STAT, 8'h03);
		rdc(rcr_pkg::ADDR_IRQ_STAT, 8'h00);
		rdc(8'h1C, 8'h00);
	endtask

	initial
	begin
		repeat (5) @(posedge mclk_i);
		reset_i <= 1'b0;
		wait_rst();
		t_por();
		t_sw();
		t_mix();
		t_ram();
		t_wdog();
		t_irq();
		final_report();
	end

	// a hang is cut short well past the fewer than two hundred cycles of the tests
	initial
	begin
		#40000;
		fail_count++;
		final_report();
	end
endmodule
